// ---- hw/channel_rate_filter_config.sv ----
// apb register bank for per-channel rate dividers and filter selection
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module channel_rate_filter_config (
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rate_filter_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode strap and base rate strobe pin
  input wire logic mode_master,
  input wire logic base_rate_strobe_in,
  output logic base_rate_strobe_out,
  output logic base_rate_strobe_oe,
  // configuration to the filter datapath
  output logic [1:0] rate_divider_chan0,
  output logic [1:0] rate_divider_chan1,
  output logic [1:0] rate_divider_chan2,
  output logic [1:0] rate_divider_chan3,
  output logic [1:0] filter_type_chan0,
  output logic [1:0] filter_type_chan1,
  output logic [1:0] filter_type_chan2,
  output logic [1:0] filter_type_chan3,
  output logic wide_bw_chan0,
  output logic wide_bw_chan1,
  output logic wide_bw_chan2,
  output logic wide_bw_chan3,
  output logic [3:0] narrow_passband,
  output logic base_strobe,
  output logic [3:0] chan_strobe
);

  localparam int NCH = rate_filter_pkg::NUM_CHAN;
  localparam int FW = rate_filter_pkg::CHAN_FIELD_W;

  // mask of divider count bits that must be zero for a channel strobe
  function automatic logic [rate_filter_pkg::DIV_CNT_W-1:0] div_mask(
    input logic [1:0] code
  );
    logic [rate_filter_pkg::DIV_CNT_W-1:0] m;
    m = 3'h0;
    unique case (code)
      rate_filter_pkg::RATE_DIV_1: m = 3'h0;
      rate_filter_pkg::RATE_DIV_2: m = 3'h1;
      rate_filter_pkg::RATE_DIV_4: m = 3'h3;
      rate_filter_pkg::RATE_DIV_8: m = 3'h7;
    endcase
    return m;
  endfunction

  // bandwidth bit counts only under the wideband filter
  function automatic logic narrow_active(input logic [1:0] ftype, input logic bw);
    return bw && (rate_filter_pkg::filter_type_t'(ftype) == rate_filter_pkg::FILTER_WIDEBAND);
  endfunction

  logic [7:0] int_low_q;
  logic [7:0] int_mid_q;
  logic [7:0] int_high_q;
  logic [7:0] frac_low_q;
  logic [7:0] frac_mid0_q;
  logic [7:0] frac_mid1_q;
  logic [7:0] frac_top_q;
  logic [7:0] rate_div_q;
  logic [7:0] filter_type_q;
  logic [3:0] bw_sel_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  logic [5:0] index;
  logic aligned;
  logic mapped;
  logic setup;
  logic wr_en;
  logic [7:0] wbyte;
  logic [31:0] rd_word;

  logic mode_meta_q;
  logic mode_sync_q;
  logic strobe_meta_q;
  logic strobe_sync_q;
  logic strobe_prev_q;
  logic gen_strobe;
  logic base_strobe_q;
  logic [rate_filter_pkg::DIV_CNT_W-1:0] div_cnt_q [NCH];

  // address decode
  assign index = paddr[rate_filter_pkg::ADDR_W-1:rate_filter_pkg::WORD_LSB];
  assign aligned = (paddr[rate_filter_pkg::WORD_LSB-1:0] == 2'h0);
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && mapped && !pslverr_q && pstrb[0];
  assign wbyte = pwdata[7:0];

  always_comb begin
    mapped = aligned;
    unique case (index)
      rate_filter_pkg::IDX_DEC_INT_LOW,
      rate_filter_pkg::IDX_DEC_INT_MID,
      rate_filter_pkg::IDX_DEC_INT_HIGH,
      rate_filter_pkg::IDX_DEC_FRAC_LOW,
      rate_filter_pkg::IDX_DEC_FRAC_MID0,
      rate_filter_pkg::IDX_DEC_FRAC_MID1,
      rate_filter_pkg::IDX_DEC_FRAC_TOP,
      rate_filter_pkg::IDX_CHANNEL_RATE_DIVIDER,
      rate_filter_pkg::IDX_CHANNEL_FILTER_TYPE,
      rate_filter_pkg::IDX_WIDEBAND_BW_SELECT,
      rate_filter_pkg::IDX_MODE_STATUS: mapped = aligned;
      default: mapped = 1'b0;
    endcase
  end

  // read mux, narrow registers sit in the low byte
  always_comb begin
    rd_word = 32'h0;
    unique case (index)
      rate_filter_pkg::IDX_DEC_INT_LOW: rd_word[7:0] = int_low_q;
      rate_filter_pkg::IDX_DEC_INT_MID: rd_word[7:0] = int_mid_q;
      rate_filter_pkg::IDX_DEC_INT_HIGH: rd_word[7:0] = int_high_q;
      rate_filter_pkg::IDX_DEC_FRAC_LOW: rd_word[7:0] = frac_low_q;
      rate_filter_pkg::IDX_DEC_FRAC_MID0: rd_word[7:0] = frac_mid0_q;
      rate_filter_pkg::IDX_DEC_FRAC_MID1: rd_word[7:0] = frac_mid1_q;
      rate_filter_pkg::IDX_DEC_FRAC_TOP: rd_word[7:0] = frac_top_q;
      rate_filter_pkg::IDX_CHANNEL_RATE_DIVIDER: rd_word[7:0] = rate_div_q;
      rate_filter_pkg::IDX_CHANNEL_FILTER_TYPE: rd_word[7:0] = filter_type_q;
      rate_filter_pkg::IDX_WIDEBAND_BW_SELECT: rd_word[3:0] = bw_sel_q;
      rate_filter_pkg::IDX_MODE_STATUS: rd_word[0] = mode_sync_q;
      default: rd_word = 32'h0;
    endcase
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0 : rd_word;
      pslverr_q <= !mapped;
    end
  end

  // zero wait state slave
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q && psel && penable;

  // integer part of the decimation ratio
  always_ff @(posedge clk) begin
    if (rst) begin
      int_low_q <= rate_filter_pkg::RST_DEC_INT_LOW;
      int_mid_q <= rate_filter_pkg::RST_DEC_INT_MID;
      int_high_q <= rate_filter_pkg::RST_DEC_INT_HIGH;
    end else if (wr_en) begin
      if (index == rate_filter_pkg::IDX_DEC_INT_LOW) int_low_q <= wbyte;
      if (index == rate_filter_pkg::IDX_DEC_INT_MID) int_mid_q <= wbyte;
      if (index == rate_filter_pkg::IDX_DEC_INT_HIGH) int_high_q <= wbyte;
    end
  end

  // fractional part of the decimation ratio
  always_ff @(posedge clk) begin
    if (rst) begin
      frac_low_q <= rate_filter_pkg::RST_DEC_FRAC_LOW;
      frac_mid0_q <= rate_filter_pkg::RST_DEC_FRAC_MID0;
      frac_mid1_q <= rate_filter_pkg::RST_DEC_FRAC_MID1;
      frac_top_q <= rate_filter_pkg::RST_DEC_FRAC_TOP;
    end else if (wr_en) begin
      if (index == rate_filter_pkg::IDX_DEC_FRAC_LOW) frac_low_q <= wbyte;
      if (index == rate_filter_pkg::IDX_DEC_FRAC_MID0) frac_mid0_q <= wbyte;
      if (index == rate_filter_pkg::IDX_DEC_FRAC_MID1) frac_mid1_q <= wbyte;
      if (index == rate_filter_pkg::IDX_DEC_FRAC_TOP) frac_top_q <= wbyte;
    end
  end

  // per-channel rate divider byte
  always_ff @(posedge clk) begin
    if (rst) begin
      rate_div_q <= rate_filter_pkg::RST_CHANNEL_RATE_DIVIDER;
    end else if (wr_en && index == rate_filter_pkg::IDX_CHANNEL_RATE_DIVIDER) begin
      rate_div_q <= wbyte;
    end
  end

  // per-channel filter selector byte
  always_ff @(posedge clk) begin
    if (rst) begin
      filter_type_q <= rate_filter_pkg::RST_CHANNEL_FILTER_TYPE;
    end else if (wr_en && index == rate_filter_pkg::IDX_CHANNEL_FILTER_TYPE) begin
      filter_type_q <= wbyte;
    end
  end

  // wideband bandwidth bits, upper nibble not stored
  always_ff @(posedge clk) begin
    if (rst) begin
      bw_sel_q <= rate_filter_pkg::RST_WIDEBAND_BW_SELECT;
    end else if (wr_en && index == rate_filter_pkg::IDX_WIDEBAND_BW_SELECT) begin
      bw_sel_q <= wbyte[rate_filter_pkg::BW_FIELD_W-1:0];
    end
  end

  // field breakout, channel 3 highest
  assign rate_divider_chan0 = rate_div_q[1*FW-1:0*FW];
  assign rate_divider_chan1 = rate_div_q[2*FW-1:1*FW];
  assign rate_divider_chan2 = rate_div_q[3*FW-1:2*FW];
  assign rate_divider_chan3 = rate_div_q[4*FW-1:3*FW];
  assign filter_type_chan0 = filter_type_q[1*FW-1:0*FW];
  assign filter_type_chan1 = filter_type_q[2*FW-1:1*FW];
  assign filter_type_chan2 = filter_type_q[3*FW-1:2*FW];
  assign filter_type_chan3 = filter_type_q[4*FW-1:3*FW];
  assign wide_bw_chan0 = bw_sel_q[0];
  assign wide_bw_chan1 = bw_sel_q[1];
  assign wide_bw_chan2 = bw_sel_q[2];
  assign wide_bw_chan3 = bw_sel_q[3];

  // high selects the 0.10825 passband, low the 0.433 one
  always_comb begin
    narrow_passband[0] = narrow_active(filter_type_chan0, wide_bw_chan0);
    narrow_passband[1] = narrow_active(filter_type_chan1, wide_bw_chan1);
    narrow_passband[2] = narrow_active(filter_type_chan2, wide_bw_chan2);
    narrow_passband[3] = narrow_active(filter_type_chan3, wide_bw_chan3);
  end

  // two-flop synchronisers for the mode strap and strobe pin
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_meta_q <= 1'b0;
      mode_sync_q <= 1'b0;
      strobe_meta_q <= 1'b0;
      strobe_sync_q <= 1'b0;
      strobe_prev_q <= 1'b0;
    end else begin
      mode_meta_q <= mode_master;
      mode_sync_q <= mode_meta_q;
      strobe_meta_q <= base_rate_strobe_in;
      strobe_sync_q <= strobe_meta_q;
      strobe_prev_q <= strobe_sync_q;
    end
  end

  // rate generator runs only in master mode
  rate_strobe_gen #(
    .INT_W(rate_filter_pkg::DEC_INT_W),
    .FRAC_W(rate_filter_pkg::DEC_FRAC_W)
  ) u_rate_gen (
    .clk(clk),
    .rst(rst),
    .enable(mode_sync_q),
    .dec_integer({int_high_q, int_mid_q, int_low_q}),
    .dec_fraction({frac_top_q, frac_mid1_q, frac_mid0_q, frac_low_q}),
    .strobe(gen_strobe)
  );

  // base strobe from generator in master mode, from pin rising edge in slave
  always_ff @(posedge clk) begin
    if (rst) begin
      base_strobe_q <= 1'b0;
    end else if (mode_sync_q) begin
      base_strobe_q <= gen_strobe;
    end else begin
      base_strobe_q <= strobe_sync_q && !strobe_prev_q;
    end
  end

  assign base_strobe = base_strobe_q;
  assign base_rate_strobe_out = mode_sync_q && base_strobe_q;
  assign base_rate_strobe_oe = mode_sync_q;

  // per-channel divide counters over base strobes
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        div_cnt_q[i] <= '0;
      end
    end else if (base_strobe_q) begin
      for (int i = 0; i < NCH; i++) begin
        div_cnt_q[i] <= div_cnt_q[i] + 3'h1;
      end
    end
  end

  // channel strobe when the masked count is zero
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      chan_strobe[i] = base_strobe_q &&
        ((div_cnt_q[i] & div_mask(rate_div_q[i*FW +: FW])) == 3'h0);
    end
  end

endmodule

// ---- hw/rate_filter_pkg.sv ----
// constants and types for the channel rate and filter configuration bank
package rate_filter_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [5:0] IDX_DEC_INT_LOW = 6'h16;
  localparam logic [5:0] IDX_DEC_INT_MID = 6'h17;
  localparam logic [5:0] IDX_DEC_INT_HIGH = 6'h18;
  localparam logic [5:0] IDX_DEC_FRAC_LOW = 6'h19;
  localparam logic [5:0] IDX_DEC_FRAC_MID0 = 6'h1a;
  localparam logic [5:0] IDX_DEC_FRAC_MID1 = 6'h1b;
  localparam logic [5:0] IDX_DEC_FRAC_TOP = 6'h1c;
  localparam logic [5:0] IDX_CHANNEL_RATE_DIVIDER = 6'h1d;
  localparam logic [5:0] IDX_CHANNEL_FILTER_TYPE = 6'h1e;
  localparam logic [5:0] IDX_WIDEBAND_BW_SELECT = 6'h1f;
  localparam logic [5:0] IDX_MODE_STATUS = 6'h20;

  // byte address layout
  localparam int ADDR_W = 8;
  localparam int WORD_LSB = 2;

  // reset values
  localparam logic [7:0] RST_DEC_INT_LOW = 8'h40;
  localparam logic [7:0] RST_DEC_INT_MID = 8'h00;
  localparam logic [7:0] RST_DEC_INT_HIGH = 8'h00;
  localparam logic [7:0] RST_DEC_FRAC_LOW = 8'h72;
  localparam logic [7:0] RST_DEC_FRAC_MID0 = 8'hb7;
  localparam logic [7:0] RST_DEC_FRAC_MID1 = 8'hce;
  localparam logic [7:0] RST_DEC_FRAC_TOP = 8'h2b;
  localparam logic [7:0] RST_CHANNEL_RATE_DIVIDER = 8'h00;
  localparam logic [7:0] RST_CHANNEL_FILTER_TYPE = 8'h00;
  localparam logic [3:0] RST_WIDEBAND_BW_SELECT = 4'h0;

  // field layout
  localparam int NUM_CHAN = 4;
  localparam int CHAN_FIELD_W = 2;
  localparam int BW_FIELD_W = 4;
  localparam int DEC_INT_W = 24;
  localparam int DEC_FRAC_W = 32;
  localparam int DIV_CNT_W = 3;

  // filter choices of a two-bit selector
  typedef enum logic [1:0] {
    FILTER_WIDEBAND = 2'h0,
    FILTER_SINC6 = 2'h1,
    FILTER_SINC3 = 2'h2,
    FILTER_SINC3_REJECT = 2'h3
  } filter_type_t;

  // rate divider codes
  localparam logic [1:0] RATE_DIV_1 = 2'h0;
  localparam logic [1:0] RATE_DIV_2 = 2'h1;
  localparam logic [1:0] RATE_DIV_4 = 2'h2;
  localparam logic [1:0] RATE_DIV_8 = 2'h3;

endpackage

// ---- hw/rate_strobe_gen.sv ----
// fractional rate generator that makes the base rate strobe from the clock
`timescale 1ns/1ns
module rate_strobe_gen #(
  parameter int INT_W = 24,
  parameter int FRAC_W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [INT_W-1:0] dec_integer,
  input wire logic [FRAC_W-1:0] dec_fraction,
  output logic strobe
);

  localparam int ACC_W = INT_W + FRAC_W + 1;
  localparam logic [ACC_W-1:0] ONE_CLOCK = {{(INT_W){1'b0}}, 1'b1, {(FRAC_W){1'b0}}};

  logic [ACC_W-1:0] ratio;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_sum;
  logic hit;

  // ratio is integer plus fraction times two to the minus fraction width
  assign ratio = {1'b0, dec_integer, dec_fraction};
  assign acc_sum = acc_q + ONE_CLOCK;
  // a ratio below one clock fires on every clock
  assign hit = (acc_sum >= ratio);

  // phase accumulator, one clock worth added each edge
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      acc_q <= '0;
    end else if (hit) begin
      acc_q <= (ratio > acc_sum) ? '0 : acc_sum - ratio;
    end else begin
      acc_q <= acc_sum;
    end
  end

  // registered one-cycle strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      strobe <= 1'b0;
    end else begin
      strobe <= enable && hit;
    end
  end

endmodule

// ---- testbench/apb_host.sv ----
// host model that runs register transfers on the bus
`timescale 1ns/1ns
module apb_host (
  input wire logic clk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  // idle bus at time zero
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  // setup, access held until ready, then release with data turned over
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    pwdata <= ~d;
  endtask
endmodule

// ---- testbench/rate_filter_sva.sv ----
// assertion checker for the rate and filter configuration bank
`timescale 1ns/1ns
module rate_filter_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rate_filter_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic base_rate_strobe_in,
  input wire logic base_rate_strobe_out,
  input wire logic base_rate_strobe_oe,
  input wire logic [1:0] rate_divider_chan0,
  input wire logic [1:0] rate_divider_chan1,
  input wire logic [1:0] rate_divider_chan2,
  input wire logic [1:0] rate_divider_chan3,
  input wire logic [1:0] filter_type_chan0,
  input wire logic [1:0] filter_type_chan1,
  input wire logic [1:0] filter_type_chan2,
  input wire logic [1:0] filter_type_chan3,
  input wire logic wide_bw_chan0,
  input wire logic wide_bw_chan1,
  input wire logic wide_bw_chan2,
  input wire logic wide_bw_chan3,
  input wire logic [3:0] narrow_passband,
  input wire logic base_strobe,
  input wire logic [3:0] chan_strobe
);
  logic wr;
  logic [7:0] div_b;
  logic [7:0] flt_b;
  logic [3:0] bw_b;
  // write qualifier, the two packed configuration bytes and the packed bandwidth nibble
  assign wr = psel && penable && pwrite && pstrb[0];
  assign div_b = {rate_divider_chan3, rate_divider_chan2, rate_divider_chan1, rate_divider_chan0};
  assign flt_b = {filter_type_chan3, filter_type_chan2, filter_type_chan1, filter_type_chan0};
  assign bw_b = {wide_bw_chan3, wide_bw_chan2, wide_bw_chan1, wide_bw_chan0};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  div_write_a: assert property (wr && paddr == 8'h74 |=> div_b == $past(pwdata[7:0]))
    else $error("divider byte not taken");
  filter_write_a: assert property (wr && paddr == 8'h78 |=>
    flt_b == $past(pwdata[7:0])) else $error("filter byte not taken");
  bw_write_a: assert property (wr && paddr == 8'h7c |=> bw_b == $past(pwdata[3:0]))
    else $error("bandwidth bits not taken");
  bw_reserved_a: assert property (psel && penable && !pwrite && paddr == 8'h7c |->
    prdata[31:4] == 28'h0) else $error("reserved bandwidth bits not zero");
  reset_fields_a: assert property ($fell(rst) |->
    {div_b, flt_b, bw_b} == 20'h0) else $error("fields not at reset value");
  narrow_gate_a: assert property (narrow_passband == (bw_b & {
    flt_b[7:6] == 2'h0, flt_b[5:4] == 2'h0, flt_b[3:2] == 2'h0, flt_b[1:0] == 2'h0}))
    else $error("passband gate wrong");
  pin_drive_a: assert property (base_rate_strobe_out ==
    (base_rate_strobe_oe && base_strobe)) else $error("strobe pin drive wrong");
  chan_subset_a: assert property (chan_strobe != 4'h0 |-> base_strobe)
    else $error("channel strobe without base strobe");
  full_rate_a: assert property (base_strobe && rate_divider_chan0 == 2'h0 |->
    chan_strobe[0]) else $error("full rate channel missed a strobe");
  slave_follow_a: assert property (!base_rate_strobe_oe && $rose(base_rate_strobe_in)
    ##3 !base_rate_strobe_oe |-> base_strobe) else $error("slave strobe late");
  cover property (wr && paddr == 8'h74);
  cover property (base_strobe && chan_strobe == 4'hf);
  cover property (base_rate_strobe_oe && base_strobe);
endmodule
bind channel_rate_filter_config rate_filter_sva u_sva (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .base_rate_strobe_in(base_rate_strobe_in),
  .base_rate_strobe_out(base_rate_strobe_out), .base_rate_strobe_oe(base_rate_strobe_oe),
  .rate_divider_chan0(rate_divider_chan0), .rate_divider_chan1(rate_divider_chan1),
  .rate_divider_chan2(rate_divider_chan2), .rate_divider_chan3(rate_divider_chan3),
  .filter_type_chan0(filter_type_chan0), .filter_type_chan1(filter_type_chan1),
  .filter_type_chan2(filter_type_chan2), .filter_type_chan3(filter_type_chan3),
  .wide_bw_chan0(wide_bw_chan0), .wide_bw_chan1(wide_bw_chan1), .wide_bw_chan2(wide_bw_chan2),
  .wide_bw_chan3(wide_bw_chan3), .narrow_passband(narrow_passband),
  .base_strobe(base_strobe), .chan_strobe(chan_strobe));

// ---- testbench/tb.sv ----
// testbench for the channel rate and filter configuration bank
`timescale 1ns/1ns
module tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic mode_master = 1'h0;
  logic strobe_pin = 1'h0;
  logic psel, penable, pwrite, pready, pslverr, out_pin, pin_oe, base_strobe;
  logic bw0, bw1, bw2, bw3;
  logic [1:0] rd0, rd1, rd2, rd3, ft0, ft1, ft2, ft3;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, narrow_passband, chan_strobe;
  logic [32:0] exp_q[$];
  logic [7:0] vals[4];
  logic [7:0] rst_tab[10] = '{8'h40, 8'h00, 8'h00, 8'h72, 8'hb7, 8'hce, 8'h2b, 8'h00, 8'h00, 8'h00};
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int n_base = 0;
  int n_chan[4] = '{default: 0};
  always #5 clk = ~clk;
  apb_host host (.clk(clk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  channel_rate_filter_config dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_master(mode_master),
    .base_rate_strobe_in(strobe_pin), .base_rate_strobe_out(out_pin),
    .base_rate_strobe_oe(pin_oe), .rate_divider_chan0(rd0), .rate_divider_chan1(rd1),
    .rate_divider_chan2(rd2), .rate_divider_chan3(rd3), .filter_type_chan0(ft0),
    .filter_type_chan1(ft1), .filter_type_chan2(ft2), .filter_type_chan3(ft3),
    .wide_bw_chan0(bw0), .wide_bw_chan1(bw1), .wide_bw_chan2(bw2), .wide_bw_chan3(bw3),
    .narrow_passband(narrow_passband), .base_strobe(base_strobe), .chan_strobe(chan_strobe));
  // one comparison, counted
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // note the answer {error, read data} and run the transfer
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [32:0] e);
    exp_q.push_back(e);
    host.xfer(w, a, d, s);
  endtask
  // pulse the external strobe pin, two cycles high and two low
  task automatic pins(input int n);
    repeat (n) begin
      @(posedge clk);
      strobe_pin <= 1'h1;
      repeat (2) @(posedge clk);
      strobe_pin <= 1'h0;
      @(posedge clk);
    end
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'h1;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    n_base = 0;
    n_chan = '{default: 0};
  endtask
  // monitor: completed transfers against notes, strobe counts, hang limit
  always @(negedge clk) begin
    if (psel && penable && pready)
      check({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
    if (base_strobe === 1'h1) n_base++;
    for (int i = 0; i < 4; i++) if (chan_strobe[i] === 1'h1) n_chan[i]++;
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'ha7aa));
    do_reset();
    // reset values of the ratio and configuration bytes, slave mode
    for (int i = 0; i < 10; i++)
      acc(1'h0, 8'h58 + 8'(4 * i), 32'h0, 4'hf, {25'h0, rst_tab[i]});
    acc(1'h0, 8'h80, 32'h0, 4'hf, 33'h0);
    // random bytes written and read back, reserved bandwidth bits dropped
    for (int i = 0; i < 4; i++) begin
      vals[i] = 8'($urandom);
      acc(1'h1, 8'h70 + 8'(4 * i), {24'h0, vals[i]}, 4'hf, 33'h0);
      acc(1'h0, 8'h70 + 8'(4 * i), 32'h0, 4'hf,
          {25'h0, (i == 3) ? {4'h0, vals[i][3:0]} : vals[i]});
    end
    // write without byte strobe ignored; unmapped and misaligned answer an error
    acc(1'h1, 8'h74, {24'h0, ~vals[1]}, 4'he, 33'h0);
    acc(1'h0, 8'h74, 32'h0, 4'hf, {25'h0, vals[1]});
    acc(1'h1, 8'h84, 32'h1, 4'hf, {1'h1, 32'h0});
    // a misaligned read flags the error but still shows the word it decoded to
    acc(1'h0, 8'h75, 32'h0, 4'hf, {1'h1, 24'h0, vals[1]});
    // every filter code on all channels with every bandwidth bit set
    acc(1'h1, 8'h7c, 32'hff, 4'hf, 33'h0);
    for (int c = 0; c < 4; c++) begin
      acc(1'h1, 8'h78, {24'h0, {4{2'(c)}}}, 4'hf, 33'h0);
      @(negedge clk);
      check({25'h0, ft3, ft2, ft1, ft0}, {25'h0, {4{2'(c)}}});
      check({25'h0, narrow_passband, bw3, bw2, bw1, bw0},
            {25'h0, (c == 0) ? 4'hf : 4'h0, 4'hf});
    end
    // slave strobes after a second reset, divider codes 3,2,1,0 from channel 3 down
    do_reset();
    acc(1'h1, 8'h74, 32'he4, 4'hf, 33'h0);
    pins(16);
    repeat (4) @(posedge clk);
    check({1'h0, 8'(n_chan[0]), 8'(n_chan[1]), 8'(n_chan[2]), 8'(n_chan[3])},
          {1'h0, 8'h10, 8'h08, 8'h04, 8'h02});
    // master mode with a ratio of exactly ten clocks
    acc(1'h1, 8'h58, 32'ha, 4'hf, 33'h0);
    for (int i = 0; i < 4; i++) acc(1'h1, 8'h64 + 8'(4 * i), 32'h0, 4'hf, 33'h0);
    mode_master <= 1'h1;
    repeat (10) @(posedge clk);
    n_base = 0;
    repeat (200) @(posedge clk);
    check({1'h0, 32'(n_base)}, 33'h14);
    check({32'h0, pin_oe}, 33'h1);
    acc(1'h0, 8'h80, 32'h0, 4'hf, 33'h1);
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule
